// >>> rmcsc_map.vh
// Constants for the relay multiplexer channel and scan control block
`ifndef RMCSC_MAP_VH
`define RMCSC_MAP_VH
`define RMCSC_OP_CLOSE    4'h0
`define RMCSC_OP_OPEN     4'h1
`define RMCSC_OP_SCAN     4'h2
`define RMCSC_OP_INIT     4'h3
`define RMCSC_OP_ABORT    4'h4
`define RMCSC_OP_Q_CLOSED 4'h5
`define RMCSC_OP_Q_OPEN   4'h6
`define RMCSC_OP_SET_OUTP 4'h7
`define RMCSC_OP_Q_OUTP   4'h8
`define RMCSC_OP_SET_CONT 4'h9
`define RMCSC_OP_Q_STAT   4'hA
`define RMCSC_OP_TRIG     4'hB
`define RMCSC_CARD_MAX    7'h63
`define RMCSC_CHAN_MAX    7'h0F
`define RMCSC_TREE_BASE   7'h5A
`define RMCSC_TREE_LAST   7'h5D
`define RMCSC_CHANS       16
`define RMCSC_TREES       4
`define RMCSC_RST_CHAN    16'h0000
`define RMCSC_RST_TREE    4'h0
`define RMCSC_CLK_KHZ     20000
`define RMCSC_PULSE_NS    1000
`endif

// >>> rmcsc_sync.v
// Two-stage synchroniser for an asynchronous pin
module rmcsc_sync (
  input  wire clk_sys,
  input  wire nrst,
  input  wire din,
  output reg  dout
);
  reg meta_reg;

  // Only the second stage is visible outside
  always @(posedge clk_sys) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      dout     <= 1'b0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule

// >>> rmcsc_tpulse.v
// Active-low trigger output pulse stretcher
module rmcsc_tpulse #(
  parameter PULSE_CYC = 20
) (
  input  wire clk_sys,
  input  wire nrst,
  input  wire fire,
  output reg  trig_out_n
);
  reg [15:0] cnt_reg;
  reg [3:0]  pend_reg;
  reg        gap_reg;
  wire       start;

  // Closures that land during a pulse wait their turn, so up to fifteen queued each still get their own edge
  assign start = trig_out_n && !gap_reg && (fire || (pend_reg != 4'h0));

  always @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_reg    <= 16'h0000;
      pend_reg   <= 4'h0;
      gap_reg    <= 1'b0;
      trig_out_n <= 1'b1;
    end else begin
      gap_reg <= 1'b0;
      // Saturates: a burst beyond fifteen queued closures loses pulses
      if (fire && !start && (pend_reg != 4'hF)) begin
        pend_reg <= pend_reg + 4'h1;
      end else if (!fire && start) begin
        pend_reg <= pend_reg - 4'h1;
      end
      if (start) begin
        cnt_reg    <= PULSE_CYC[15:0] - 16'h0001;
        trig_out_n <= 1'b0;
      end else if (!trig_out_n) begin
        if (cnt_reg != 16'h0000) begin
          cnt_reg <= cnt_reg - 16'h0001;
        end else begin
          trig_out_n <= 1'b1;
          gap_reg    <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> rmcsc_top.v
// Channel state store, command decode and scan sequencer
`include "rmcsc_map.vh"
module rmcsc_top #(
  parameter       DEPTH   = 16,
  parameter       IDX_W   = 4,
  parameter [6:0] CARD_ID = 7'h01
) (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        cmd_valid,
  input  wire [3:0]  cmd_op,
  input  wire [6:0]  cmd_card,
  input  wire [6:0]  cmd_first,
  input  wire [6:0]  cmd_last,
  input  wire        cmd_end,
  input  wire        cmd_arg,
  input  wire        trig_src_ext,
  input  wire        trig_ext_pin,
  output reg         resp_valid,
  output reg         resp_bit,
  output reg         scan_err,
  output reg  [15:0] chan_closed,
  output reg  [3:0]  tree_closed,
  output reg         outp_en,
  output reg         cont_mode,
  output reg         list_valid,
  output reg         scan_done,
  output wire        scan_active,
  output wire        trig_out_n
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_MAKE  = 2'b01;
  localparam ST_RUN   = 2'b10;
  localparam ST_BREAK = 2'b11;
  localparam PULSE_CYC = (`RMCSC_PULSE_NS * `RMCSC_CLK_KHZ + 999999) / 1000000;

  // Inclusive range membership, used for channels, trees and the query decode
  function hit;
    input integer   code;
    input [6:0]     lo;
    input [6:0]     hi;
    begin
      hit = (code >= lo) && (code <= hi);
    end
  endfunction

  reg  [1:0]       state_reg;
  reg  [IDX_W-1:0] idx_reg;
  reg  [3:0]       pos_reg;
  reg  [IDX_W:0]   wr_idx_reg;
  reg  [IDX_W:0]   cnt_reg;
  reg              bad_reg;
  reg              fire_reg;
  reg              ext_d_reg;
  reg  [3:0]       ent_first [0:DEPTH-1];
  reg  [3:0]       ent_last  [0:DEPTH-1];
  reg              ent_own   [0:DEPTH-1];
  wire             ext_s;
  wire             take;
  wire             own;
  wire             ent_ok;
  wire             trig;
  wire [15:0]      set_mask;
  wire [15:0]      clr_mask;
  wire [3:0]       tset_mask;
  wire [3:0]       tclr_mask;
  wire             q_chan;
  wire             q_tree;
  wire [6:0]       q_off;
  wire             q_closed;
  wire             at_ent_end;
  wire             at_list_end;
  wire             stat_read;
  wire             done_set;
  wire             bad_next;
  wire [IDX_W-1:0] idx_inc;
  wire [IDX_W:0]   idx_cnt;
  wire             hold_seq;
  wire             seq_step;
  wire             card_ok;
  wire             span_ok;

  rmcsc_sync u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (trig_ext_pin),
    .dout    (ext_s)
  );

  // Each card drives its own copy; the enable gates only this card's pulses
  rmcsc_tpulse #(
    .PULSE_CYC (PULSE_CYC)
  ) u_tpulse (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .fire       (fire_reg),
    .trig_out_n (trig_out_n)
  );

  assign take = cmd_valid;
  assign own  = (cmd_card == CARD_ID);
  assign card_ok = (cmd_card <= `RMCSC_CARD_MAX);
  assign span_ok = hit(cmd_first, 7'h00, `RMCSC_CHAN_MAX) &&
                   hit(cmd_last, cmd_first, `RMCSC_CHAN_MAX);
  assign ent_ok  = card_ok && span_ok;
  // Bus triggers count only while the bus is the selected source
  assign trig = trig_src_ext ? (ext_s & ~ext_d_reg) :
                (take && (cmd_op == `RMCSC_OP_TRIG));

  genvar g;
  generate
    for (g = 0; g < `RMCSC_CHANS; g = g + 1) begin : g_chan
      assign set_mask[g] = take && own && (cmd_op == `RMCSC_OP_CLOSE) &&
                           hit(g, cmd_first, cmd_last);
      assign clr_mask[g] = take && own && (cmd_op == `RMCSC_OP_OPEN) &&
                           hit(g, cmd_first, cmd_last);
    end
    for (g = 0; g < `RMCSC_TREES; g = g + 1) begin : g_tree
      assign tset_mask[g] = take && own && (cmd_op == `RMCSC_OP_CLOSE) &&
                            hit(g + `RMCSC_TREE_BASE, cmd_first, cmd_last);
      assign tclr_mask[g] = take && own && (cmd_op == `RMCSC_OP_OPEN) &&
                            hit(g + `RMCSC_TREE_BASE, cmd_first, cmd_last);
    end
  endgenerate

  // Queries read the stored vectors only; a welded or dead relay goes unseen
  assign q_chan   = hit(cmd_first, 7'h00, `RMCSC_CHAN_MAX);
  assign q_tree   = hit(cmd_first, `RMCSC_TREE_BASE, `RMCSC_TREE_LAST);
  assign q_off    = cmd_first - `RMCSC_TREE_BASE;
  assign q_closed = q_chan ? chan_closed[cmd_first[3:0]] : tree_closed[q_off[1:0]];

  assign idx_inc     = idx_reg + {{(IDX_W-1){1'b0}}, 1'b1};
  assign idx_cnt     = {1'b0, idx_reg} + {{IDX_W{1'b0}}, 1'b1};
  assign at_ent_end  = (pos_reg == ent_last[idx_reg]);
  assign at_list_end = at_ent_end && (idx_cnt == cnt_reg);
  // Start, stop and redefine all preempt the sequencer for that cycle
  assign hold_seq    = take && ((cmd_op == `RMCSC_OP_SCAN) || (cmd_op == `RMCSC_OP_ABORT) ||
                                (cmd_op == `RMCSC_OP_INIT));
  assign seq_step    = (state_reg == ST_RUN) && trig && !hold_seq;
  assign stat_read   = take && (cmd_op == `RMCSC_OP_Q_STAT);
  assign done_set    = seq_step && at_list_end;
  assign bad_next    = bad_reg || !ent_ok || (wr_idx_reg == DEPTH[IDX_W:0]);
  assign scan_active = (state_reg != ST_IDLE);

  always @(posedge clk_sys) begin
    if (!nrst) begin
      ext_d_reg <= 1'b0;
    end else begin
      ext_d_reg <= ext_s;
    end
  end

  // Scan list storage; plain flops indexed by the write pointer
  always @(posedge clk_sys) begin
    if (take && (cmd_op == `RMCSC_OP_SCAN) && (wr_idx_reg < DEPTH[IDX_W:0])) begin
      ent_first[wr_idx_reg[IDX_W-1:0]] <= cmd_first[3:0];
      ent_last[wr_idx_reg[IDX_W-1:0]]  <= cmd_last[3:0];
      ent_own[wr_idx_reg[IDX_W-1:0]]   <= own;
    end
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      chan_closed <= `RMCSC_RST_CHAN;
      tree_closed <= `RMCSC_RST_TREE;
      outp_en     <= 1'b0;
      cont_mode   <= 1'b0;
      list_valid  <= 1'b0;
      scan_done   <= 1'b0;
      resp_valid  <= 1'b0;
      resp_bit    <= 1'b0;
      scan_err    <= 1'b0;
      fire_reg    <= 1'b0;
      bad_reg     <= 1'b0;
      wr_idx_reg  <= {(IDX_W+1){1'b0}};
      cnt_reg     <= {(IDX_W+1){1'b0}};
      idx_reg     <= {IDX_W{1'b0}};
      pos_reg     <= 4'h0;
      state_reg   <= ST_IDLE;
    end else begin
      resp_valid  <= 1'b0;
      scan_err    <= 1'b0;
      fire_reg    <= 1'b0;
      // One store serves both relay drive and readback
      chan_closed <= (chan_closed | set_mask) & ~clr_mask;
      tree_closed <= (tree_closed | tset_mask) & ~tclr_mask;
      // A completion in the same cycle as the read survives the clear
      scan_done   <= done_set | (scan_done & ~stat_read);

      if (take) begin
        case (cmd_op)
          `RMCSC_OP_SET_OUTP: begin
            outp_en <= cmd_arg;
          end
          `RMCSC_OP_SET_CONT: begin
            cont_mode <= cmd_arg;
          end
          `RMCSC_OP_Q_OUTP: begin
            resp_valid <= 1'b1;
            resp_bit   <= outp_en;
          end
          `RMCSC_OP_Q_STAT: begin
            resp_valid <= 1'b1;
            resp_bit   <= scan_done;
          end
          `RMCSC_OP_Q_CLOSED: begin
            if (own && (q_chan || q_tree)) begin
              resp_valid <= 1'b1;
              resp_bit   <= q_closed;
            end
          end
          `RMCSC_OP_Q_OPEN: begin
            if (own && (q_chan || q_tree)) begin
              resp_valid <= 1'b1;
              resp_bit   <= ~q_closed;
            end
          end
          `RMCSC_OP_SCAN: begin
            // A list being redefined cannot be scanned at the same time
            list_valid <= 1'b0;
            state_reg  <= ST_IDLE;
            if (cmd_end) begin
              wr_idx_reg <= {(IDX_W+1){1'b0}};
              bad_reg    <= 1'b0;
              if (bad_next) begin
                scan_err <= 1'b1;
              end else begin
                list_valid <= 1'b1;
                cnt_reg    <= wr_idx_reg + {{IDX_W{1'b0}}, 1'b1};
              end
            end else begin
              bad_reg <= bad_next;
              if (wr_idx_reg < DEPTH[IDX_W:0]) begin
                wr_idx_reg <= wr_idx_reg + {{IDX_W{1'b0}}, 1'b1};
              end
            end
          end
          `RMCSC_OP_INIT: begin
            if (list_valid) begin
              idx_reg   <= {IDX_W{1'b0}};
              pos_reg   <= ent_first[0];
              // A restart mid-scan opens the channel in hand and breaks first
              if ((state_reg == ST_RUN) && ent_own[idx_reg]) begin
                chan_closed[pos_reg] <= 1'b0;
              end
              state_reg <= scan_active ? ST_BREAK : ST_MAKE;
            end else begin
              scan_err <= 1'b1;
            end
          end
          `RMCSC_OP_ABORT: begin
            list_valid <= 1'b0;
            state_reg  <= ST_IDLE;
          end
          default: begin
          end
        endcase
      end

      // Sequencer: make, wait for a trigger, break, make the next
      case (state_reg)
        ST_MAKE: begin
          if (!hold_seq) begin
            if (ent_own[idx_reg]) begin
              chan_closed[pos_reg] <= 1'b1;
              fire_reg             <= outp_en;
            end
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (seq_step) begin
            // Break before make: the old channel opens two cycles ahead
            if (ent_own[idx_reg]) begin
              chan_closed[pos_reg] <= 1'b0;
            end
            if (!at_ent_end) begin
              pos_reg   <= pos_reg + 4'h1;
              state_reg <= ST_BREAK;
            end else if (!at_list_end) begin
              idx_reg   <= idx_inc;
              pos_reg   <= ent_first[idx_inc];
              state_reg <= ST_BREAK;
            end else if (cont_mode) begin
              idx_reg   <= {IDX_W{1'b0}};
              pos_reg   <= ent_first[0];
              state_reg <= ST_BREAK;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_BREAK: begin
          if (!hold_seq) begin
            state_reg <= ST_MAKE;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// >>> rmcsc_chk_asserts.sv
// Concurrent checks on the ports of the channel and scan control block
`include "rmcsc_map.vh"
module rmcsc_chk #(
  parameter [6:0] CARD_ID = 7'h01
) (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_op,
  input wire logic [6:0]  cmd_card,
  input wire logic [6:0]  cmd_first,
  input wire logic [6:0]  cmd_last,
  input wire logic        cmd_end,
  input wire logic        resp_valid,
  input wire logic        resp_bit,
  input wire logic        scan_err,
  input wire logic [15:0] chan_closed,
  input wire logic [3:0]  tree_closed,
  input wire logic        outp_en,
  input wire logic        list_valid,
  input wire logic        scan_done,
  input wire logic        trig_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [15:0] rng_mask = (16'hFFFF << cmd_first[3:0]) & (16'hFFFF >> (4'hF - cmd_last[3:0]));
  wire        own_cmd  = cmd_valid && cmd_card == CARD_ID;
  wire        chan_rng = cmd_first <= cmd_last && cmd_last <= 7'h0F;
  wire        sel_bit  = chan_closed[cmd_first[3:0]];
  wire [1:0]  tree_idx = cmd_first[1:0] - 2'b10;
  wire        one_tree = cmd_first == cmd_last && cmd_first >= 7'h5A && cmd_first <= 7'h5D;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_reset_opens: assert property (disable iff (1'b0) !nrst |=> chan_closed == 16'h0000
    && tree_closed == 4'h0 && !outp_en && trig_out_n) else $error("reset state wrong");
  a_close_range: assert property (own_cmd && cmd_op == `RMCSC_OP_CLOSE && chan_rng
    |=> (chan_closed & $past(rng_mask)) == $past(rng_mask)) else $error("close missed");
  a_open_range: assert property (own_cmd && cmd_op == `RMCSC_OP_OPEN && chan_rng
    |=> (chan_closed & $past(rng_mask)) == 16'h0000) else $error("open missed");
  a_tree_close: assert property (own_cmd && cmd_op == `RMCSC_OP_CLOSE && one_tree
    |=> tree_closed[$past(tree_idx)]) else $error("tree switch not closed");
  a_closed_query: assert property (own_cmd && cmd_op == `RMCSC_OP_Q_CLOSED
    && cmd_first <= 7'h0F |=> resp_valid && resp_bit == $past(sel_bit))
    else $error("closed query wrong");
  a_open_query: assert property (own_cmd && cmd_op == `RMCSC_OP_Q_OPEN
    && cmd_first <= 7'h0F |=> resp_valid && resp_bit != $past(sel_bit))
    else $error("open query wrong");
  a_enable_query: assert property (cmd_valid && cmd_op == `RMCSC_OP_Q_OUTP
    |=> resp_valid && resp_bit == $past(outp_en)) else $error("enable query wrong");
  a_status_query: assert property (cmd_valid && cmd_op == `RMCSC_OP_Q_STAT
    |=> resp_valid && resp_bit == $past(scan_done)) else $error("status query wrong");
  a_list_reject: assert property (cmd_valid && cmd_op == `RMCSC_OP_SCAN && cmd_end
    && cmd_card > `RMCSC_CARD_MAX |=> scan_err && !list_valid) else $error("bad list kept");
  a_pulse_low: assert property ($fell(trig_out_n) |=> !trig_out_n [*8])
    else $error("trigger pulse too short");
  a_pulse_enabled: assert property ($fell(trig_out_n) |-> $past(outp_en))
    else $error("pulse while disabled");
endmodule
bind rmcsc_top rmcsc_chk #(.CARD_ID(CARD_ID)) i_rmcsc_chk (.clk_sys(clk_sys), .nrst(nrst),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_card(cmd_card), .cmd_first(cmd_first),
  .cmd_last(cmd_last), .cmd_end(cmd_end), .resp_valid(resp_valid), .resp_bit(resp_bit),
  .scan_err(scan_err), .chan_closed(chan_closed), .tree_closed(tree_closed),
  .outp_en(outp_en), .list_valid(list_valid), .scan_done(scan_done), .trig_out_n(trig_out_n));

// >>> rmcsc_host.sv
// Host command model driving the command port of the scan control block
module rmcsc_host (
  input  wire logic  clk_sys,
  output logic       cmd_valid,
  output logic [3:0] cmd_op,
  output logic [6:0] cmd_card,
  output logic [6:0] cmd_first,
  output logic [6:0] cmd_last,
  output logic       cmd_end,
  output logic       cmd_arg
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    {cmd_op, cmd_card, cmd_first, cmd_last, cmd_end, cmd_arg} = 27'h0;
  end
  // One command a call; the gap cycle keeps the strobe from toggling twice in a step
  task send(input logic [3:0] op, input logic [6:0] card, first, last, input logic f);
    @(negedge clk_sys);
    cmd_op = op;
    cmd_card = card;
    cmd_first = first;
    cmd_last = last;
    cmd_end = f;
    cmd_arg = f;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    // Released op and channel fields show garbage, not the last command
    {cmd_op, cmd_first, cmd_last} = ~{cmd_op, cmd_first, cmd_last};
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the channel and scan control block
`include "rmcsc_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        trig_src_ext = 1'b0;
  logic        trig_ext_pin = 1'b0;
  logic        cmd_valid, cmd_end, cmd_arg, resp_valid, resp_bit, scan_err, outp_en;
  logic        cont_mode, list_valid, scan_done, scan_active, trig_out_n;
  logic [3:0]  cmd_op, tree_closed;
  logic [6:0]  cmd_card, cmd_first, cmd_last;
  logic [15:0] chan_closed;
  int          err_count = 0;
  int          total_checks = 0;
  int          pulses = 0;
  int          k;
  always #25 clk_sys = ~clk_sys;
  always @(negedge trig_out_n) pulses++;
  rmcsc_host i_rmcsc_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_card(cmd_card), .cmd_first(cmd_first), .cmd_last(cmd_last), .cmd_end(cmd_end),
    .cmd_arg(cmd_arg));
  rmcsc_top i_rmcsc_top (.clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_card(cmd_card), .cmd_first(cmd_first), .cmd_last(cmd_last),
    .cmd_end(cmd_end), .cmd_arg(cmd_arg), .trig_src_ext(trig_src_ext),
    .trig_ext_pin(trig_ext_pin), .resp_valid(resp_valid), .resp_bit(resp_bit),
    .scan_err(scan_err), .chan_closed(chan_closed), .tree_closed(tree_closed),
    .outp_en(outp_en), .cont_mode(cont_mode), .list_valid(list_valid),
    .scan_done(scan_done), .scan_active(scan_active), .trig_out_n(trig_out_n));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task cmd(input logic [3:0] op, input logic [6:0] first, last, input logic f);
    i_rmcsc_host.send(op, 7'h01, first, last, f);
  endtask
  // Bounded wait for the answer strobe, then compare its bit
  task q(input logic [3:0] op, input logic [6:0] ch, input logic exp);
    int i;
    cmd(op, ch, ch, 1'b0);
    for (i = 0; i < 4 && resp_valid !== 1'b1; i++) @(negedge clk_sys);
    chk(resp_bit, exp);
    if (i == 4) begin
      err_count++;
      end_sim;
    end
  endtask
  // Long settle so each trigger pulse ends before the next closure
  task wait_chan(input logic [15:0] exp);
    int i;
    for (i = 0; i < 40 && chan_closed !== exp; i++) @(negedge clk_sys);
    chk(chan_closed, exp);
    if (i == 40) begin
      err_count++;
      end_sim;
    end
    repeat (24) @(negedge clk_sys);
  endtask
  task pin_trig;
    trig_ext_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    trig_ext_pin = 1'b0;
  endtask
  // At most one channel closed at any time while a scan is active
  always @(negedge clk_sys) begin
    if (scan_active === 1'b1 && $countones(chan_closed) > 1) begin
      chk(0, 1);
    end
  end
  initial begin
    repeat (6) @(negedge clk_sys);
    chk({chan_closed, tree_closed, outp_en, trig_out_n}, {16'h0, 4'h0, 2'b01});
    nrst = 1'b1;
    cmd(`RMCSC_OP_CLOSE, 7'h02, 7'h05, 1'b0);
    chk(chan_closed, 16'h003C);
    i_rmcsc_host.send(`RMCSC_OP_CLOSE, 7'h02, 7'h00, 7'h00, 1'b0);
    chk(chan_closed, 16'h003C);
    q(`RMCSC_OP_Q_CLOSED, 7'h03, 1'b1);
    q(`RMCSC_OP_Q_OPEN, 7'h03, 1'b0);
    q(`RMCSC_OP_Q_OPEN, 7'h00, 1'b1);
    cmd(`RMCSC_OP_OPEN, 7'h03, 7'h04, 1'b0);
    chk(chan_closed, 16'h0024);
    for (k = 0; k < 4; k++) begin
      cmd(`RMCSC_OP_CLOSE, 7'h5A + 7'(k), 7'h5A + 7'(k), 1'b0);
      chk(tree_closed, (32'h2 << k) - 32'h1);
    end
    cmd(`RMCSC_OP_OPEN, 7'h5C, 7'h5C, 1'b0);
    chk(tree_closed, 4'hB);
    q(`RMCSC_OP_Q_OUTP, 7'h00, 1'b0);
    cmd(`RMCSC_OP_SET_OUTP, 7'h00, 7'h00, 1'b1);
    q(`RMCSC_OP_Q_OUTP, 7'h00, 1'b1);
    i_rmcsc_host.send(`RMCSC_OP_SCAN, 7'h64, 7'h00, 7'h00, 1'b1);
    chk({scan_err, list_valid}, 2'b10);
    cmd(`RMCSC_OP_SCAN, 7'h09, 7'h08, 1'b1);
    chk({scan_err, list_valid}, 2'b10);
    cmd(`RMCSC_OP_OPEN, 7'h00, 7'h0F, 1'b0);
    cmd(`RMCSC_OP_SCAN, 7'h06, 7'h07, 1'b1);
    chk(list_valid, 1'b1);
    cmd(`RMCSC_OP_INIT, 7'h00, 7'h00, 1'b0);
    wait_chan(16'h0040);
    cmd(`RMCSC_OP_TRIG, 7'h00, 7'h00, 1'b0);
    wait_chan(16'h0080);
    cmd(`RMCSC_OP_TRIG, 7'h00, 7'h00, 1'b0);
    wait_chan(16'h0000);
    chk({scan_active, scan_done, trig_out_n}, 3'b011);
    q(`RMCSC_OP_Q_STAT, 7'h00, 1'b1);
    chk(scan_done, 1'b0);
    chk(pulses, 2);
    cmd(`RMCSC_OP_SET_CONT, 7'h00, 7'h00, 1'b1);
    cmd(`RMCSC_OP_SET_OUTP, 7'h00, 7'h00, 1'b0);
    trig_src_ext = 1'b1;
    cmd(`RMCSC_OP_INIT, 7'h00, 7'h00, 1'b0);
    wait_chan(16'h0040);
    pin_trig;
    wait_chan(16'h0080);
    pin_trig;
    wait_chan(16'h0040);
    chk(scan_active, 1'b1);
    chk(pulses, 2);
    cmd(`RMCSC_OP_ABORT, 7'h00, 7'h00, 1'b0);
    cmd(`RMCSC_OP_SET_OUTP, 7'h00, 7'h00, 1'b1);
    // Second reset with a channel, trees, the enable and continuous mode all set
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({chan_closed, tree_closed, outp_en, cont_mode, scan_active}, 23'h0);
    end_sim;
  end
endmodule
